// file: verilog/frc_map.svh
// Register map, field positions, reset values and timing of the fault block.
// Assumes a 250 MHz core clock; included by its bare name.
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH
`define FRC_ADDR_PID     6'h00
`define FRC_ADDR_RAW1    6'h01
`define FRC_ADDR_AVG1    6'h05
`define FRC_ADDR_FLAGS   6'h12
`define FRC_ADDR_MASK    6'h13
`define FRC_ADDR_CTRL    6'h14
`define FRC_HDR_READ     1'b1
`define FRC_FLG_LINK     8
`define FRC_FLG_FRAME    9
`define FRC_FLG_STREAM   10
`define FRC_FLG_CONV     11
`define FRC_CTL_REBOOT   0
`define FRC_CTL_SOFT     1
`define FRC_CTL_PORCLR   2
`define FRC_CTL_PWROFF   3
`define FRC_CTL_FLUSH    4
`define FRC_CTL_SHARED   8
`define FRC_CTL_CHKEN    9
`define FRC_PID_POR      15
`define FRC_PID_CODE     15'h0a5c  // Arbitrary identity value
`define FRC_RST_WORD     16'h0000
`define FRC_LEN_SINGLE   7'h18
`define FRC_LEN_SINGLEC  7'h20
`define FRC_LEN_BURST    7'h58
`define FRC_LEN_BURSTC   7'h60
`define FRC_LEN_HDR      7'h07
`define FRC_CLK_MHZ      250
`define FRC_FRAME_US     50
`define FRC_STREAM_MS    100
`define FRC_REBOOT_US    1
`define FRC_CONV_FRAMES  3'h4
`define FRC_LINK_FAILS   3'h6
`define FRC_CHK_LO       12'h010
`define FRC_CHK_HI       12'hff0
`endif

// file: verilog/frc_pkg.sv
// Types shared by the fault block.
// Assumes frc_map.svh holds the numbers.
package frc_pkg;
  typedef logic [15:0] frc_word_t;
  typedef logic [5:0]  frc_addr_t;
  typedef enum logic [1:0] {FRC_SPI_IDLE, FRC_SPI_HDR, FRC_SPI_DATA} frc_spi_t;
endpackage

// file: verilog/frc_top.sv
// Fault latch, alert line, control register and SPI slave of the logic side.
// Assumes SPI pins come from outside; frame strobe, results, check samples
// and link words arrive from logic on clk.
//
// Behaviour
// RULE1: burst 0x01 gives raw, 0x05 averaged
// RULE2: other read addresses ignore burst flag
// RULE3: alert pulls low on enabled flagged fault
// RULE4: masked fault still latches its flag
// RULE5: flag read clears; persisting faults reset
// RULE6: four bad check frames set bit 11
// RULE7: check samples interleave, sampling timing untouched
// RULE8: bad bit count sets bit 9, nothing decoded
// RULE9: stream loss masked 100ms, then bit 10
// RULE10: bad link words dropped; six set bit 8
// RULE11: stream loss recovers only by hard reset; here a good link word or a soft reset also ends it
// RULE12: control writes act at once unless deferred
// RULE13: hard reset reboots power, restores all defaults
// RULE14: soft reset at frame end, power kept
// RULE15: flag clear drops power-up flag; hard resets
// RULE16: power off stops field, core keeps running
// RULE17: filter flush at next frame, bit clears
// RULE18: shared limits use channel one thresholds
// RULE19: check enable selects 24/32 bits, default off; here 24 and 32 bits are both accepted in either setting
// RULE20: host appends check byte once enabled
// RULE21: flag set during read survives clear
// RULE22: burst is 11 bytes, 12 with check
// RULE23: frame strobe times deferred actions
`timescale 1ns/10ps
`include "frc_map.svh"
module frc_top #(
  parameter int unsigned STREAM_MASK_CYC = `FRC_STREAM_MS * 1000 * `FRC_CLK_MHZ,
  parameter int unsigned STREAM_WAIT_CYC = `FRC_FRAME_US * `FRC_CLK_MHZ
) (
  input  wire logic             clk,              // Core clock
  input  wire logic             rst_n,            // Power-on reset
  input  wire logic             sclk,             // SPI clock pin
  input  wire logic             cs_n,             // SPI select pin
  input  wire logic             sdi,              // SPI data in pin
  output logic                  sdo,              // SPI data out
  output logic                  sdo_oe,           // SPI data out enable
  output logic                  alert_o,          // Alert pin level
  output logic                  alert_oe,         // Alert pulls low
  input  wire logic             frame_tick,       // Frame boundary pulse
  input  wire logic [3:0][15:0] raw_result,       // Unfiltered results
  input  wire logic [3:0][15:0] avg_result,       // Averaged results
  input  wire logic             conv_check_valid, // Self-check sample strobe
  input  wire logic [11:0]      conv_check_code,  // Self-check sample
  input  wire logic             link_word_valid,  // Link word strobe
  input  wire logic             link_word_crc_ok, // Link word check good
  output logic                  link_word_keep,   // Link word accepted
  output logic                  core_reset,       // Core reset pulse
  output logic                  field_power_en,   // Field supply on
  output logic [3:0]            filter_flush_ch,  // Filter clear pulses
  output logic                  shared_limits,    // Channel one limits for all
  output logic                  spi_check_enable  // SPI check byte on
);
  import frc_pkg::*;

  localparam int unsigned REBOOT_CYC = `FRC_REBOOT_US * `FRC_CLK_MHZ;

  function automatic logic len_ok(input logic [6:0] n);
    len_ok = (n == `FRC_LEN_SINGLE) || (n == `FRC_LEN_SINGLEC) ||
             (n == `FRC_LEN_BURST) || (n == `FRC_LEN_BURSTC);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] sdi_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 3'h0;
      cs_q   <= 3'h7;
      sdi_q  <= 2'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q   <= {cs_q[1:0], cs_n};
      sdi_q  <= {sdi_q[0], sdi};
    end
  end
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire cs_start  = ~cs_q[1] & cs_q[2];
  wire cs_end    = cs_q[1] & ~cs_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // SPI framing
  frc_spi_t    spi_st;
  logic [6:0]  bit_cnt;
  logic [31:0] rx;
  logic [79:0] tx;
  logic [79:0] next_tx;
  frc_word_t   snap;
  logic        snap_on;
  frc_word_t   flags;
  frc_word_t   mask;
  logic        por;
  logic        soft_pend;
  logic        pwr_off;
  logic [3:0]  flush;
  logic        wipe;
  logic        hard_q;

  wire [7:0] hdr_now = {sdi_q[1], rx[6:0]};
  wire       load_tx = sclk_rise && spi_st == FRC_SPI_HDR && bit_cnt == `FRC_LEN_HDR;
  wire       rd_now  = hdr_now[6] == `FRC_HDR_READ;
  wire       brst_raw = rd_now && hdr_now[7] && hdr_now[5:0] == `FRC_ADDR_RAW1;
  wire       brst_avg = rd_now && hdr_now[7] && hdr_now[5:0] == `FRC_ADDR_AVG1;
  wire       xact_end = cs_end && spi_st != FRC_SPI_IDLE;
  wire       xact_ok  = xact_end && len_ok(bit_cnt);                     // [RULE8]
  wire       frame_err = xact_end && !len_ok(bit_cnt);                   // [RULE8]
  wire       write_go = xact_ok && rx[6] != `FRC_HDR_READ && bit_cnt >= `FRC_LEN_SINGLE;
  wire       read_clr = xact_ok && snap_on;
  wire [5:0] waddr    = rx[5:0];
  wire [15:0] wdata   = rx[23:8];

  function automatic frc_word_t reg_read(input frc_addr_t a, input frc_word_t f,
                                         input frc_word_t m, input frc_word_t c, input logic p);
    unique case (a)
      `FRC_ADDR_PID:   reg_read = {p, `FRC_PID_CODE};  // Identity code is arbitrary
      `FRC_ADDR_FLAGS: reg_read = f;
      `FRC_ADDR_MASK:  reg_read = m;
      `FRC_ADDR_CTRL:  reg_read = c;
      default:         reg_read = `FRC_RST_WORD;
    endcase
  endfunction

  wire [15:0] ctrl_rd = {6'h00, spi_check_enable, shared_limits, flush, pwr_off, 1'b0, soft_pend, 1'b0};

  always_comb
  begin
    if (brst_raw)
      next_tx = {flags, raw_result};                                     // [RULE1] [RULE22]
    else if (brst_avg)
      next_tx = {flags, avg_result};                                     // [RULE1] [RULE22]
    else if (rd_now)
      next_tx = {64'h0, reg_read(hdr_now[5:0], flags, mask, ctrl_rd, por)}; // [RULE2]
    else
      next_tx = 80'h0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spi_st  <= FRC_SPI_IDLE;
      bit_cnt <= 7'h00;
      rx      <= 32'h0;
    end
    else if (cs_start)
    begin
      spi_st  <= FRC_SPI_HDR;
      bit_cnt <= 7'h00;
    end
    else if (cs_end)
      spi_st <= FRC_SPI_IDLE;
    else if (sclk_rise)
    begin
      unique case (spi_st)
        FRC_SPI_IDLE: ;
        FRC_SPI_HDR, FRC_SPI_DATA:
        begin
          if (bit_cnt != 7'h7f)
            bit_cnt <= bit_cnt + 7'h01;
          if (bit_cnt < 7'h20)
            rx[bit_cnt[4:0]] <= sdi_q[1];
          if (load_tx)
            spi_st <= FRC_SPI_DATA;
        end
      endcase
    end
  end

  // Data goes out LSB first, changed on falling SCLK
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx      <= 80'h0;
      sdo     <= 1'b0;
      sdo_oe  <= 1'b0;
      snap    <= 16'h0;
      snap_on <= 1'b0;
    end
    else
    begin
      sdo_oe <= ~cs_q[1];
      if (cs_start)
      begin
        snap_on <= 1'b0;
        sdo     <= 1'b0;
      end
      if (load_tx)
      begin
        tx      <= next_tx;
        // Only flags seen now are cleared later
        snap    <= flags;                                                // [RULE21]
        snap_on <= brst_raw || brst_avg || (rd_now && hdr_now[5:0] == `FRC_ADDR_FLAGS);
      end
      else if (sclk_fall && spi_st == FRC_SPI_DATA)
      begin
        sdo <= tx[0];
        tx  <= {1'b0, tx[79:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and resets
  wire hard_go = write_go && waddr == `FRC_ADDR_CTRL && wdata[`FRC_CTL_REBOOT];
  wire ctl_wr  = write_go && waddr == `FRC_ADDR_CTRL;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wipe   <= 1'b0;
      hard_q <= 1'b0;
    end
    else
    begin
      wipe   <= hard_go || (soft_pend && frame_tick);                    // [RULE13] [RULE14] [RULE23]
      hard_q <= hard_go;
    end
  end
  assign core_reset = wipe;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask             <= `FRC_RST_WORD;
      soft_pend        <= 1'b0;
      pwr_off          <= 1'b0;
      flush            <= 4'h0;
      shared_limits    <= 1'b0;
      spi_check_enable <= 1'b0;
    end
    else if (wipe)
    begin
      mask             <= `FRC_RST_WORD;                                 // [RULE13] [RULE14]
      soft_pend        <= 1'b0;
      pwr_off          <= 1'b0;
      flush            <= 4'h0;
      shared_limits    <= 1'b0;
      spi_check_enable <= 1'b0;                                          // [RULE19]
    end
    else
    begin
      if (frame_tick)
        flush <= 4'h0;                                                   // [RULE17]
      if (write_go && waddr == `FRC_ADDR_MASK)
        mask <= wdata;
      if (ctl_wr && !wdata[`FRC_CTL_REBOOT])
      begin
        soft_pend        <= wdata[`FRC_CTL_SOFT];                        // [RULE12]
        pwr_off          <= wdata[`FRC_CTL_PWROFF];                      // [RULE16]
        flush            <= wdata[`FRC_CTL_FLUSH +: 4];
        shared_limits    <= wdata[`FRC_CTL_SHARED];                      // [RULE18]
        spi_check_enable <= wdata[`FRC_CTL_CHKEN];                       // [RULE19] [RULE20]
      end
    end
  end

  // Soft reset leaves the power-up flag alone
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      por <= 1'b1;
    else if (hard_q)
      por <= 1'b1;                                                       // [RULE15]
    else if (ctl_wr && wdata[`FRC_CTL_PORCLR])
      por <= 1'b0;                                                       // [RULE15]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      filter_flush_ch <= 4'h0;
    else
      filter_flush_ch <= frame_tick ? flush : 4'h0;                      // [RULE17] [RULE23]
  end

  // Field supply drops for a short reboot window after a hard reset
  logic [15:0] reboot_cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reboot_cnt     <= 16'h0;
      field_power_en <= 1'b0;
    end
    else
    begin
      if (hard_go)
        reboot_cnt <= REBOOT_CYC[15:0];                                  // [RULE13]
      else if (reboot_cnt != 16'h0)
        reboot_cnt <= reboot_cnt - 16'h1;
      field_power_en <= !pwr_off && reboot_cnt == 16'h0 && !hard_go;     // [RULE16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault detectors
  logic [31:0] mask_cnt;
  logic [31:0] gap_cnt;
  logic [2:0]  fail_cnt;
  logic [2:0]  bad_frames;
  logic [11:0] last_code;
  logic        seen;
  logic        seen_bad;

  wire stream_lost = mask_cnt == 32'h0 && gap_cnt >= STREAM_WAIT_CYC;    // [RULE9] [RULE11]
  wire link_bad    = fail_cnt == `FRC_LINK_FAILS;                        // [RULE10]
  wire conv_bad    = bad_frames == `FRC_CONV_FRAMES;                     // [RULE6]
  wire good_word   = link_word_valid && link_word_crc_ok;
  wire code_bad    = conv_check_code == last_code || conv_check_code < `FRC_CHK_LO ||
                     conv_check_code > `FRC_CHK_HI;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_cnt <= STREAM_MASK_CYC;
      gap_cnt  <= 32'h0;
    end
    else
    begin
      if (wipe)
        mask_cnt <= STREAM_MASK_CYC;                                     // [RULE9]
      else if (mask_cnt != 32'h0)
        mask_cnt <= mask_cnt - 32'h1;
      if (good_word || wipe)
        gap_cnt <= 32'h0;
      else if (gap_cnt != 32'hffffffff)
        gap_cnt <= gap_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_cnt       <= 3'h0;
      link_word_keep <= 1'b0;
    end
    else
    begin
      link_word_keep <= good_word;                                       // [RULE10]
      if (wipe || good_word)
        fail_cnt <= 3'h0;
      else if (link_word_valid && !link_bad)
        fail_cnt <= fail_cnt + 3'h1;                                     // [RULE10]
    end
  end

  // Check samples are only observed; the sampling path is never touched
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_code  <= 12'h000;
      seen       <= 1'b0;
      seen_bad   <= 1'b0;
      bad_frames <= 3'h0;
    end
    else if (wipe)
    begin
      seen       <= 1'b0;
      seen_bad   <= 1'b0;
      bad_frames <= 3'h0;
    end
    else
    begin
      if (conv_check_valid)
      begin
        last_code <= conv_check_code;                                    // [RULE7]
        seen      <= 1'b1;
        seen_bad  <= seen_bad || code_bad;
      end
      if (frame_tick)
      begin
        seen     <= 1'b0;
        seen_bad <= 1'b0;
        if (!seen || seen_bad)
          bad_frames <= conv_bad ? bad_frames : bad_frames + 3'h1;       // [RULE6] [RULE23]
        else
          bad_frames <= 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and alert
  frc_word_t set_vec;
  always_comb
  begin
    set_vec                 = 16'h0;
    set_vec[`FRC_FLG_LINK]   = link_bad;
    set_vec[`FRC_FLG_FRAME]  = frame_err;
    set_vec[`FRC_FLG_STREAM] = stream_lost;
    set_vec[`FRC_FLG_CONV]   = conv_bad;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags <= `FRC_RST_WORD;
    else if (wipe)
      flags <= `FRC_RST_WORD;
    else
      flags <= (flags & ~(read_clr ? snap : 16'h0)) | set_vec;           // [RULE4] [RULE5] [RULE21]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
    end
    else
    begin
      alert_o  <= 1'b0;
      alert_oe <= |(flags & mask);                                       // [RULE3] [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_alert_on: assert property (|(flags & mask) |=> alert_oe)   // [RULE3]
    else $error("alert not driven");
  a_alert_off: assert property (!(|(flags & mask)) |=> !alert_oe)   // [RULE3]
    else $error("alert driven without enabled flag");
  a_flag_hold: assert property (!read_clr && !wipe |=> ($past(flags) & ~flags) == 16'h0)   // [RULE4]
    else $error("flag lost without read");
  a_read_clear: assert property (read_clr && !wipe |=> (flags & $past(snap) & ~$past(set_vec)) == 16'h0)   // [RULE5]
    else $error("read did not clear flags");
  a_read_keep: assert property (read_clr && !wipe |=> ($past(flags) & ~$past(snap) & ~flags) == 16'h0)   // [RULE21]
    else $error("new flag lost at read");
  a_frame_error: assert property (frame_err && !wipe |=> flags[`FRC_FLG_FRAME] && $stable(mask))   // [RULE8]
    else $error("framing error mishandled");
  a_conv_fail: assert property (conv_bad && !wipe |=> flags[`FRC_FLG_CONV])   // [RULE6]
    else $error("converter failure not flagged");
  a_link_fail: assert property (link_bad && !wipe |=> flags[`FRC_FLG_LINK])   // [RULE10]
    else $error("link failure not flagged");
  a_stream_mask: assert property (mask_cnt != 32'h0 |-> !flags[`FRC_FLG_STREAM])   // [RULE9]
    else $error("stream loss not masked");
  a_soft_frame: assert property (soft_pend && frame_tick && !wipe |=> core_reset ##1 !soft_pend && por == $past(por))   // [RULE14]
    else $error("soft reset not at frame end");
  a_hard_reset: assert property (hard_go |=> core_reset ##1 (mask == 16'h0 && !spi_check_enable && por && !field_power_en))   // [RULE13]
    else $error("hard reset incomplete");

  c_burst_raw: cover property (load_tx && brst_raw ##[1:1000] xact_ok);
  c_burst_avg: cover property (load_tx && brst_avg ##[1:1000] xact_ok);
  c_frame_err: cover property (frame_err);
  c_soft_reset: cover property (soft_pend && frame_tick);
endmodule // frc_top

// file: verif/frc_host.sv
// SPI host model driving the serial pins of the fault block.
// Assumes a 250 MHz clk; SCLK runs at 20 clk a period, idle low outside frames.
`timescale 1ns/10ps
module frc_host (
  input  wire logic   clk,   // Core clock
  input  wire logic   sdo,   // Resolved data out line
  output logic        sclk,  // SPI clock
  output logic        cs_n,  // SPI select
  output logic        sdi,   // SPI data in
  output logic        done,  // Read result ready
  output logic [79:0] rdata  // Bits after the header
);
  initial
  begin
    {sclk, cs_n, sdi} = 3'b010;
    {done, rdata} = 81'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // LSB first; n already counts any check byte, which is never sampled
  task automatic xfer(input int n, input logic [95:0] tx, input logic rd);
    rdata = '0;
    repeat (4) @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (4) @(negedge clk);
      sdi = tx[i];
      repeat (6) @(negedge clk);
      sclk = 1'b1;
      if (i >= 8 && i < (n > 32 ? 88 : 24))
        rdata[i - 8] = sdo;
      repeat (10) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    sdi  = ~sdi;
    repeat (6) @(negedge clk);
    done = rd;
    @(negedge clk);
    done = 1'b0;
  endtask
endmodule // frc_host

// file: verif/testbench.sv
// Self-checking bench for frc_top: host model on SPI, bench drives frame strobe, results, check samples and link words.
// Assumes shortened stream-loss counts given at the instance.
`timescale 1ns/10ps
`include "frc_map.svh"
module testbench;
  import frc_pkg::*;
  logic             clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, alert_o, alert_oe;
  logic [3:0][15:0] raw_result, avg_result;
  logic             frame_tick, conv_check_valid, link_word_valid, link_word_crc_ok, link_word_keep;
  logic [11:0]      conv_check_code;
  logic             core_reset, field_power_en, shared_limits, spi_check_enable, host_done;
  logic [3:0]       filter_flush_ch, flush_seen;
  logic [79:0]      host_rdata;
  logic [79:0]      exp_q[$];
  logic             bad_link, no_link, bad_conv, chk, keep_exp;
  int               err_total, n_checks, cyc, rst_seen, seed;
  wire              sdo_w   = sdo_oe ? sdo : ~sdo;      // Released line shows the inverse
  wire              alert_w = alert_oe ? alert_o : 1'b1; // Pull-up on alert

  frc_top #(.STREAM_MASK_CYC(2000), .STREAM_WAIT_CYC(300)) u_frc_top (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .alert_o(alert_o), .alert_oe(alert_oe), .frame_tick(frame_tick), .raw_result(raw_result),
    .avg_result(avg_result), .conv_check_valid(conv_check_valid), .conv_check_code(conv_check_code),
    .link_word_valid(link_word_valid), .link_word_crc_ok(link_word_crc_ok),
    .link_word_keep(link_word_keep), .core_reset(core_reset), .field_power_en(field_power_en),
    .filter_flush_ch(filter_flush_ch), .shared_limits(shared_limits),
    .spi_check_enable(spi_check_enable));
  frc_host u_frc_host (.clk(clk), .sdo(sdo_w), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .done(host_done), .rdata(host_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd(input frc_addr_t a, input logic [79:0] e, input logic b = 1'b0, input int n = 24);
    exp_q.push_back(e);
    u_frc_host.xfer(n + 8 * chk, {88'h0, b, `FRC_HDR_READ, a}, 1'b1);
  endtask

  task automatic wr(input frc_addr_t a, input frc_word_t d);
    u_frc_host.xfer(24 + 8 * chk, {72'h0, d, 2'b00, a}, 1'b0);
  endtask

  always @(posedge host_done)
    check("spi_read", host_rdata, exp_q.pop_front());

  ////////////////////////////////////////////////////////////////////////////
  // Frame strobe every 200 clk, link word every 100 clk
  always @(negedge clk)
  begin
    cyc++;
    frame_tick       = (cyc % 200 == 0);
    conv_check_valid = (cyc % 200 == 100);
    conv_check_code  = bad_conv ? 12'h800 : 12'h100 + 12'(cyc / 200 % 256);
    link_word_valid  = !no_link && (cyc % 100 == 50);
    link_word_crc_ok = !bad_link;
    if (core_reset === 1'b1)
      rst_seen++;
    if (filter_flush_ch !== 4'h0)
      flush_seen = filter_flush_ch;
    if (cyc % 100 == 50)
      keep_exp = link_word_valid && link_word_crc_ok;
    if (cyc % 100 == 51 && rst_n)
      check("link_keep", link_word_keep, keep_exp);
  end

  initial
  begin
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(negedge clk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    {clk, rst_n, bad_link, no_link, bad_conv, chk, keep_exp} = 7'b0;
    {frame_tick, conv_check_valid, link_word_valid, link_word_crc_ok} = 4'b0001;
    conv_check_code = 12'h100;
    flush_seen = 4'h0;
    {err_total, n_checks, cyc, rst_seen} = 128'h0;
    seed = 32'h739d;
    for (int i = 0; i < 4; i++)
    begin
      raw_result[i] = 16'($random(seed));
      avg_result[i] = 16'($random(seed));
    end
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("power_on", field_power_en, 1'b1);
    rd(`FRC_ADDR_PID, {1'b1, `FRC_PID_CODE});
    rd(`FRC_ADDR_MASK, `FRC_RST_WORD);
    rd(`FRC_ADDR_CTRL, `FRC_RST_WORD);
    rd(6'h3f, 16'h0);
    rd(`FRC_ADDR_RAW1, {16'h0, raw_result}, 1'b1, 88);
    rd(`FRC_ADDR_AVG1, {16'h0, avg_result}, 1'b1, 88);
    wr(`FRC_ADDR_MASK, 16'h0a00);
    rd(`FRC_ADDR_MASK, 16'h0a00, 1'b1);
    u_frc_host.xfer(16, {88'h0, 2'b00, `FRC_ADDR_MASK}, 1'b0);  // Short frame is refused
    check("alert_frame", alert_w, 1'b0);
    rd(`FRC_ADDR_FLAGS, 16'h1 << `FRC_FLG_FRAME);
    rd(`FRC_ADDR_FLAGS, 16'h0);
    check("alert_clear", alert_w, 1'b1);
    rd(`FRC_ADDR_MASK, 16'h0a00);
    // Bad link words also starve the stream, so both flags rise
    bad_link = 1'b1;
    repeat (800) @(negedge clk);
    check("alert_masked", alert_w, 1'b1);
    rd(`FRC_ADDR_FLAGS, 16'h0500);
    bad_link = 1'b0;
    repeat (300) @(negedge clk);
    rd(`FRC_ADDR_FLAGS, 16'h0500);
    rd(`FRC_ADDR_FLAGS, 16'h0);
    bad_conv = 1'b1;
    repeat (1200) @(negedge clk);
    check("alert_conv", alert_w, 1'b0);
    rd(`FRC_ADDR_FLAGS, 16'h1 << `FRC_FLG_CONV);
    bad_conv = 1'b0;
    wr(`FRC_ADDR_CTRL, 16'h0310);
    chk = 1'b1;
    check("shared", shared_limits, 1'b1);
    check("check_en", spi_check_enable, 1'b1);
    repeat (250) @(negedge clk);
    check("flush", flush_seen, 4'h1);
    rd(`FRC_ADDR_CTRL, 16'h0300);
    rd(`FRC_ADDR_AVG1, {16'h1 << `FRC_FLG_CONV, avg_result}, 1'b1, 88);
    wr(`FRC_ADDR_CTRL, 16'h0308);
    check("field_off", field_power_en, 1'b0);
    rd(`FRC_ADDR_PID, {1'b1, `FRC_PID_CODE});
    wr(`FRC_ADDR_CTRL, 16'h0304);
    rd(`FRC_ADDR_PID, {1'b0, `FRC_PID_CODE});
    wr(`FRC_ADDR_CTRL, 16'h0302);
    repeat (250) @(negedge clk);
    chk = 1'b0;
    check("soft_pulse", rst_seen, 1);
    check("field_kept", field_power_en, 1'b1);
    rd(`FRC_ADDR_CTRL, `FRC_RST_WORD);
    rd(`FRC_ADDR_PID, {1'b0, `FRC_PID_CODE});
    no_link = 1'b1;
    wr(`FRC_ADDR_MASK, 16'h1 << `FRC_FLG_STREAM);
    check("loss_masked", alert_w, 1'b1);
    repeat (1000) @(negedge clk);
    check("loss_alert", alert_w, 1'b0);
    rd(`FRC_ADDR_FLAGS, 16'h1 << `FRC_FLG_STREAM);
    wr(`FRC_ADDR_CTRL, 16'h0001);
    check("reboot_pulse", rst_seen, 2);
    check("reboot_power", field_power_en, 1'b0);
    no_link = 1'b0;
    repeat (300) @(negedge clk);
    check("power_back", field_power_en, 1'b1);
    rd(`FRC_ADDR_PID, {1'b1, `FRC_PID_CODE});
    rd(`FRC_ADDR_MASK, `FRC_RST_WORD);
    rd(`FRC_ADDR_FLAGS, `FRC_RST_WORD);
    end_of_test();
  end
endmodule // testbench
